// >>> hw/cpu_clock_ctl.v
// per-processor clock logic: duty throttling and level 2 / level 3 idle entry
`timescale 1ns/100ps
`include "cpu_pm_defs.vh"
module cpu_clock_ctl (
    input  wire                   sys_clk_i,
    input  wire                   rst_n_i,
    input  wire                   throttle_tick_i,
    input  wire                   throttle_enable_i,
    input  wire [`DUTY_WIDTH-1:0] duty_i,
    input  wire                   level2_rd_i,
    input  wire                   level3_rd_i,
    input  wire                   irq_i,
    input  wire                   bm_req_i,
    input  wire                   bus_master_wake_enable_i,
    output reg                    stop_clock_n_o,
    output reg  [1:0]             idle_state_o
);
    reg [`DUTY_WIDTH-1:0] phase_r;
    reg [1:0]             idle_nxt;

    // phase runs 0..2^width-1; processor runs while phase < duty
    always @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            phase_r <= {`DUTY_WIDTH{1'b0}};
        end else if (!throttle_enable_i) begin
            phase_r <= {`DUTY_WIDTH{1'b0}};
        end else if (throttle_tick_i) begin
            phase_r <= phase_r + 1'b1;
        end
    end

    always @* begin
        idle_nxt = idle_state_o;
        case (idle_state_o)
            `IDLE_RUN: begin
                if (level3_rd_i) begin
                    idle_nxt = `IDLE_LEVEL3;
                end else if (level2_rd_i) begin
                    idle_nxt = `IDLE_LEVEL2;
                end
            end
            `IDLE_LEVEL2: begin
                if (irq_i) begin
                    idle_nxt = `IDLE_RUN;
                end
            end
            `IDLE_LEVEL3: begin
                if (irq_i || (bm_req_i && bus_master_wake_enable_i)) begin
                    idle_nxt = `IDLE_RUN;
                end
            end
            default: idle_nxt = `IDLE_RUN;
        endcase
    end

    always @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            idle_state_o   <= `IDLE_RUN;
            stop_clock_n_o <= 1'b1;
        end else begin
            idle_state_o <= idle_nxt;
            if (idle_nxt != `IDLE_RUN) begin
                stop_clock_n_o <= 1'b0;
            end else begin
                // exactly duty of every 2^width ticks run, never fewer
                stop_clock_n_o <= !throttle_enable_i || (phase_r < duty_i);
            end
        end
    end
endmodule // cpu_clock_ctl

// >>> hw/cpu_pm_defs.vh
// constants for the processor power state and event status block
`ifndef CPU_PM_DEFS_VH
`define CPU_PM_DEFS_VH

// word offsets inside the i/o window (byte address = offset, io_be_i selects the byte, bit 0 ignored)
`define OFS_EVENT_STATUS   8'h00
`define OFS_EVENT_ENABLE   8'h02
`define OFS_PM_CONTROL     8'h04
`define OFS_TIMER_LO       8'h08
`define OFS_TIMER_HI       8'h0a
`define OFS_CPU_BASE       8'h10
`define OFS_CPU_STRIDE     8'h08
`define OFS_CPU_CONTROL    8'h00
`define OFS_CPU_LEVEL      8'h04
`define OFS_CPU_LEVEL3_BYTE 1'b1

// event status / enable bit positions
`define BIT_TIMER_CARRY    0
`define BIT_BUS_MASTER     4
`define BIT_GLOBAL_RELEASE 5
`define BIT_POWER_BUTTON   8
`define BIT_SLEEP_BUTTON   9
`define STATUS_IMPL_MASK   16'h0331
`define ENABLE_IMPL_MASK   16'h0321
`define STATUS_RESET       16'h0000

// power management control bit positions
`define BIT_ROUTE_SELECT   0
`define BIT_BM_WAKE_EN     1
`define CONTROL_IMPL_MASK  16'h0003

// processor control: duty field and throttle enable
`define DUTY_OFFSET        1
`define DUTY_WIDTH         3
`define BIT_THROTTLE_EN    4
`define CPU_CTRL_MASK      16'h001e

// idle state codes
`define IDLE_RUN           2'b00
`define IDLE_LEVEL2        2'b01
`define IDLE_LEVEL3        2'b10

// timing
`define CLK_FREQ_KHZ       40000
`define OVERRIDE_TIME_MS   4000
`define THROTTLE_DIV       16'd999
`define TIMER_DIV          8'd10
`define TIMER_BITS         24

`endif

// >>> hw/cpu_power_state_and_pm_status.v
// processor power state control and fixed event status registers
//
// How it works
// - with throttling on, processor runs duty/2^width of time, never less.
// - throttled performance equals the programmed level exactly, never below it.
// - active-low stop-clock is pulsed periodically to emulate a divided clock.
// - reading the level-2 entry register puts that processor into idle level 2.
// - reading the level-3 entry register puts that processor into idle level 3.
// - each processor has its own register block and identical clock logic.
// - unimplemented event bits read zero and ignore writes; enable also lacks bus master bit 4.
// - registers accept any byte-granular access width up to full width.
// - each grouping sits at its own 32-bit aligned address, byte or word access.
// - event status resets to zero and is cleared before entering working state.
// - timer carry flag sets on every counter msb toggle; with enable raises event.
// - bus master flag sets on any bus request, cleared by writing one or by entering working state.
// - global release flag sets when firmware releases the lock, raising an event.
// - power button flag sets on press, write-one clear; wakes always when asleep.
// - button held over four seconds clears its flag and, when not sleeping, forces soft-off.
// - a power button wake sets its flag before software resumes.
// - sleep button flag sets on press, write-one clear; wakes only when enabled.
// - a sleep button wake sets its flag before software resumes.
// - status bits 1-3 and 6-7 have no function and read zero.
// - route select steers events to os interrupt when set, firmware otherwise.
// - with bus master wake enabled, bus requests end idle level 3.
`timescale 1ns/100ps
`include "cpu_pm_defs.vh"
module cpu_power_state_and_pm_status #(
    parameter NUM_CPU          = 2,
    parameter OVERRIDE_CYCLES  = `OVERRIDE_TIME_MS * `CLK_FREQ_KHZ
) (
    input  wire                 sys_clk_i,
    input  wire                 rst_n_i,
    input  wire [7:0]           io_addr_i,
    input  wire [1:0]           io_be_i,
    input  wire                 io_rd_i,
    input  wire                 io_wr_i,
    input  wire [15:0]          io_wdata_i,
    output reg  [15:0]          io_rdata_o,
    input  wire                 power_button_i,
    input  wire                 sleep_button_i,
    input  wire                 bm_req_i,
    input  wire                 fw_lock_release_i,
    input  wire                 ext_irq_i,
    input  wire                 sleeping_i,
    input  wire                 enter_working_i,
    output wire                 os_event_interrupt_o,
    output wire                 firmware_mgmt_interrupt_o,
    output reg                  wake_o,
    output reg                  soft_off_o,
    output wire [NUM_CPU-1:0]   stop_clock_n_o,
    output wire [2*NUM_CPU-1:0] idle_state_o
);
    localparam OVR_W = 28;
    localparam [OVR_W-1:0] OVR_LIMIT = OVERRIDE_CYCLES[OVR_W-1:0];

    reg  [15:0]            event_status_r;
    reg  [15:0]            event_status_nxt;
    reg  [15:0]            event_enable_r;
    reg  [15:0]            pm_control_r;
    reg  [15:0]            cpu_ctrl_r [0:NUM_CPU-1];
    reg  [`TIMER_BITS-1:0] timer_r;
    reg  [7:0]             timer_div_r;
    reg  [15:0]            thr_div_r;
    reg                    thr_tick_r;
    reg  [OVR_W-1:0]       ovr_cnt_r;
    reg                    pwr_q_r;
    reg                    slp_q_r;
    reg                    gbl_q_r;
    reg  [15:0]            rdata_nxt;
    wire [4:0]             pin_raw;
    wire [4:0]             pin_lvl;
    wire                   pwr_lvl;
    wire                   slp_lvl;
    wire                   bm_lvl;
    wire                   gbl_lvl;
    wire                   irq_lvl;
    wire [15:0]            wmask;
    wire [15:0]            pending;
    wire                   any_event;
    wire                   pwr_press;
    wire                   slp_press;
    wire                   gbl_rise;
    wire                   timer_tick;
    wire                   timer_carry;
    wire                   override_hit;
    wire [NUM_CPU-1:0]     cpu_sel;

    //////////////////////////////////////////////////////////////////////////
    // pin synchronisers
    assign pin_raw = {ext_irq_i, fw_lock_release_i, bm_req_i, sleep_button_i, power_button_i};

    genvar g;
    generate
        for (g = 0; g < 5; g = g + 1) begin : g_sync
            pin_sync3 u_sync (
                .sys_clk_i (sys_clk_i),
                .rst_n_i   (rst_n_i),
                .pin_i     (pin_raw[g]),
                .level_o   (pin_lvl[g])
            );
        end
    endgenerate

    assign pwr_lvl = pin_lvl[0];
    assign slp_lvl = pin_lvl[1];
    assign bm_lvl  = pin_lvl[2];
    assign gbl_lvl = pin_lvl[3];
    assign irq_lvl = pin_lvl[4];

    always @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            pwr_q_r <= 1'b0;
            slp_q_r <= 1'b0;
            gbl_q_r <= 1'b0;
        end else begin
            pwr_q_r <= pwr_lvl;
            slp_q_r <= slp_lvl;
            gbl_q_r <= gbl_lvl;
        end
    end

    assign pwr_press = pwr_lvl && !pwr_q_r;
    assign slp_press = slp_lvl && !slp_q_r;
    assign gbl_rise  = gbl_lvl && !gbl_q_r;

    //////////////////////////////////////////////////////////////////////////
    // dividers, free-running timer, power button override counter
    assign timer_tick  = (timer_div_r == `TIMER_DIV);
    assign timer_carry = timer_tick &&
                         (timer_r[`TIMER_BITS-2:0] == {(`TIMER_BITS-1){1'b1}});
    assign override_hit = pwr_lvl && (ovr_cnt_r == OVR_LIMIT);

    always @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            timer_div_r <= 8'h00;
            timer_r     <= {`TIMER_BITS{1'b0}};
            thr_div_r   <= 16'h0000;
            thr_tick_r  <= 1'b0;
            ovr_cnt_r   <= {OVR_W{1'b0}};
            soft_off_o  <= 1'b0;
        end else begin
            timer_div_r <= timer_tick ? 8'h00 : timer_div_r + 8'h01;
            if (timer_tick) begin
                timer_r <= timer_r + 1'b1;
            end
            thr_tick_r <= (thr_div_r == `THROTTLE_DIV);
            thr_div_r  <= (thr_div_r == `THROTTLE_DIV) ? 16'h0000 : thr_div_r + 16'h0001;
            // held-button timer counts every cycle while held, clears on release, stops at the limit
            if (!pwr_lvl) begin
                ovr_cnt_r <= {OVR_W{1'b0}};
            end else if (ovr_cnt_r != OVR_LIMIT) begin
                ovr_cnt_r <= ovr_cnt_r + 1'b1;
            end
            soft_off_o <= override_hit && !sleeping_i;
        end
    end

    //////////////////////////////////////////////////////////////////////////
    // address decode
    assign wmask = {{8{io_be_i[1]}}, {8{io_be_i[0]}}};

    generate
        for (g = 0; g < NUM_CPU; g = g + 1) begin : g_sel
            assign cpu_sel[g] = (io_addr_i[7:3] == ((`OFS_CPU_BASE + g * `OFS_CPU_STRIDE) >> 3));
        end
    endgenerate

    //////////////////////////////////////////////////////////////////////////
    // event status: hardware set wins over write-one clear
    always @* begin
        event_status_nxt = event_status_r;
        if (io_wr_i && io_addr_i[7:1] == `OFS_EVENT_STATUS >> 1) begin
            event_status_nxt = event_status_r & ~(io_wdata_i & wmask);
        end
        if (timer_carry) begin
            event_status_nxt[`BIT_TIMER_CARRY] = 1'b1;
        end
        if (bm_lvl) begin
            event_status_nxt[`BIT_BUS_MASTER] = 1'b1;
        end
        if (gbl_rise) begin
            event_status_nxt[`BIT_GLOBAL_RELEASE] = 1'b1;
        end
        if (pwr_press) begin
            event_status_nxt[`BIT_POWER_BUTTON] = 1'b1;
        end
        if (slp_press) begin
            event_status_nxt[`BIT_SLEEP_BUTTON] = 1'b1;
        end
        if (override_hit) begin
            event_status_nxt[`BIT_POWER_BUTTON] = 1'b0;
        end
        if (enter_working_i) begin
            event_status_nxt = `STATUS_RESET;
        end
        event_status_nxt = event_status_nxt & `STATUS_IMPL_MASK;
    end

    //////////////////////////////////////////////////////////////////////////
    // writable registers
    integer i;
    integer j;
    always @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            event_status_r <= `STATUS_RESET;
            event_enable_r <= 16'h0000;
            pm_control_r   <= 16'h0000;
            for (i = 0; i < NUM_CPU; i = i + 1) begin
                cpu_ctrl_r[i] <= 16'h0000;
            end
        end else begin
            event_status_r <= event_status_nxt;
            if (enter_working_i) begin
                event_enable_r <= 16'h0000;
            end else if (io_wr_i && io_addr_i[7:1] == `OFS_EVENT_ENABLE >> 1) begin
                event_enable_r <= ((event_enable_r & ~wmask) | (io_wdata_i & wmask)) & `ENABLE_IMPL_MASK;
            end
            if (io_wr_i && io_addr_i[7:1] == `OFS_PM_CONTROL >> 1) begin
                pm_control_r <= ((pm_control_r & ~wmask) | (io_wdata_i & wmask)) & `CONTROL_IMPL_MASK;
            end
            for (i = 0; i < NUM_CPU; i = i + 1) begin
                if (io_wr_i && cpu_sel[i] && io_addr_i[2:1] == `OFS_CPU_CONTROL >> 1) begin
                    cpu_ctrl_r[i] <= ((cpu_ctrl_r[i] & ~wmask) | (io_wdata_i & wmask)) & `CPU_CTRL_MASK;
                end
            end
        end
    end

    //////////////////////////////////////////////////////////////////////////
    // interrupt routing and wake
    assign pending   = event_status_r & event_enable_r;
    assign any_event = |pending;
    assign os_event_interrupt_o      = any_event && pm_control_r[`BIT_ROUTE_SELECT];
    assign firmware_mgmt_interrupt_o = any_event && !pm_control_r[`BIT_ROUTE_SELECT];

    always @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            wake_o <= 1'b0;
        end else begin
            wake_o <= sleeping_i &&
                      (pwr_press || (slp_press && event_enable_r[`BIT_SLEEP_BUTTON]));
        end
    end

    //////////////////////////////////////////////////////////////////////////
    // read data, registered one cycle after the read strobe
    always @* begin
        rdata_nxt = 16'h0000;
        j         = 0;
        case (io_addr_i[7:1])
            `OFS_EVENT_STATUS >> 1: rdata_nxt = event_status_r;
            `OFS_EVENT_ENABLE >> 1: rdata_nxt = event_enable_r;
            `OFS_PM_CONTROL >> 1:   rdata_nxt = pm_control_r;
            `OFS_TIMER_LO >> 1:     rdata_nxt = timer_r[15:0];
            `OFS_TIMER_HI >> 1:     rdata_nxt = {{(32-`TIMER_BITS){1'b0}}, timer_r[`TIMER_BITS-1:16]};
            default: begin
                for (j = 0; j < NUM_CPU; j = j + 1) begin
                    if (cpu_sel[j] && io_addr_i[2:1] == `OFS_CPU_CONTROL >> 1) begin
                        rdata_nxt = cpu_ctrl_r[j];
                    end
                end
            end
        endcase
        rdata_nxt = rdata_nxt & wmask;
    end

    always @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            io_rdata_o <= 16'h0000;
        end else if (io_rd_i) begin
            io_rdata_o <= rdata_nxt;
        end
    end

    //////////////////////////////////////////////////////////////////////////
    // one clock logic instance per processor
    generate
        for (g = 0; g < NUM_CPU; g = g + 1) begin : g_cpu
            wire lvl_hit;
            assign lvl_hit = io_rd_i && cpu_sel[g] && io_addr_i[2:1] == `OFS_CPU_LEVEL >> 1;
            cpu_clock_ctl u_clk (
                .sys_clk_i                (sys_clk_i),
                .rst_n_i                  (rst_n_i),
                .throttle_tick_i          (thr_tick_r),
                .throttle_enable_i        (cpu_ctrl_r[g][`BIT_THROTTLE_EN]),
                .duty_i                   (cpu_ctrl_r[g][`DUTY_OFFSET+`DUTY_WIDTH-1:`DUTY_OFFSET]),
                .level2_rd_i              (lvl_hit && io_be_i[0]),
                .level3_rd_i              (lvl_hit && io_be_i[1]),
                .irq_i                    (irq_lvl || any_event),
                .bm_req_i                 (bm_lvl),
                .bus_master_wake_enable_i (pm_control_r[`BIT_BM_WAKE_EN]),
                .stop_clock_n_o           (stop_clock_n_o[g]),
                .idle_state_o             (idle_state_o[2*g+1:2*g])
            );
        end
    endgenerate
endmodule // cpu_power_state_and_pm_status

// >>> hw/pin_sync3.v
// three-stage synchroniser with agreement filter for one pin
`timescale 1ns/100ps
module pin_sync3 (
    input  wire sys_clk_i,
    input  wire rst_n_i,
    input  wire pin_i,
    output reg  level_o
);
    reg s1_r;
    reg s2_r;
    reg s3_r;

    always @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            s1_r    <= 1'b0;
            s2_r    <= 1'b0;
            s3_r    <= 1'b0;
            level_o <= 1'b0;
        end else begin
            s1_r <= pin_i;
            s2_r <= s1_r;
            s3_r <= s2_r;
            if (s2_r == s3_r) begin
                level_o <= s3_r;
            end
        end
    end
endmodule // pin_sync3

// >>> sim/cpu_model.sv
// processor model: counts the cycles in which its clock is let run
`timescale 1ns/100ps
module cpu_model (
    input  wire        sys_clk_i,
    input  wire        rst_n_i,
    input  wire        stop_clock_n_i,
    input  wire        clear_i,
    output reg  [31:0] run_cycles_o
);
    always @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            run_cycles_o <= 32'h0;
        end else if (clear_i) begin
            run_cycles_o <= 32'h0;
        end else if (stop_clock_n_i) begin
            run_cycles_o <= run_cycles_o + 32'h1;
        end
    end
endmodule // cpu_model

// >>> sim/cpu_pm_props.sv
// concurrent checks on the ports of the processor power state block
`timescale 1ns/100ps
module cpu_pm_props #(
    parameter NUM_CPU         = 2,
    parameter OVERRIDE_CYCLES = 50
) (
    input wire                 sys_clk_i,
    input wire                 rst_n_i,
    input wire [7:0]           io_addr_i,
    input wire [1:0]           io_be_i,
    input wire                 io_rd_i,
    input wire                 io_wr_i,
    input wire [15:0]          io_wdata_i,
    input wire [15:0]          io_rdata_o,
    input wire                 power_button_i,
    input wire                 sleep_button_i,
    input wire                 bm_req_i,
    input wire                 fw_lock_release_i,
    input wire                 ext_irq_i,
    input wire                 sleeping_i,
    input wire                 enter_working_i,
    input wire                 os_event_interrupt_o,
    input wire                 firmware_mgmt_interrupt_o,
    input wire                 wake_o,
    input wire                 soft_off_o,
    input wire [NUM_CPU-1:0]   stop_clock_n_o,
    input wire [2*NUM_CPU-1:0] idle_state_o
);
    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (!rst_n_i);
    ////////////////////////////////////////////////////////////////////////////////
    AST_STS_RSVD: assert property (io_rd_i && io_addr_i[7:1] == 7'h00 |=> (io_rdata_o & 16'hfcce) == 16'h0000)
        else $error("reserved status bits read nonzero");
    AST_UNMAPPED: assert property (io_rd_i && io_addr_i >= 8'h10 + 8 * NUM_CPU |=> io_rdata_o == 16'h0000)
        else $error("unmapped read returned nonzero");
    AST_IRQ_ROUTE: assert property (!(os_event_interrupt_o && firmware_mgmt_interrupt_o))
        else $error("both interrupt routes active");
    AST_L3_ENTRY: assert property (io_rd_i && io_addr_i[7:1] == 7'h0a && io_be_i == 2'b10
        |=> idle_state_o[1:0] == 2'b10 && !stop_clock_n_o[0]) else $error("level 3 read did not stop cpu0");
    AST_L2_ENTRY: assert property (io_rd_i && io_addr_i[7:1] == 7'h0e && io_be_i == 2'b01
        && !os_event_interrupt_o |=> idle_state_o[3:2] == 2'b01 && !stop_clock_n_o[1])
        else $error("level 2 read did not stop cpu1");
    AST_IRQ_EXIT: assert property (idle_state_o[3:2] != 2'b00 && os_event_interrupt_o
        |-> ##[1:2] idle_state_o[3:2] == 2'b00 && stop_clock_n_o[1]) else $error("interrupt left cpu1 idle");
    AST_WAKE_PULSE: assert property (wake_o |-> $past(sleeping_i) ##1 !wake_o)
        else $error("wake not a single pulse from sleep");
    AST_OVERRIDE: assert property ($rose(soft_off_o) |-> $past(power_button_i, 4) && !sleeping_i)
        else $error("soft off without held button");
    AST_RDATA_HOLD: assert property (!io_rd_i |=> $stable(io_rdata_o))
        else $error("read data changed without a read");
endmodule // cpu_pm_props

bind cpu_power_state_and_pm_status cpu_pm_props #(.NUM_CPU(NUM_CPU), .OVERRIDE_CYCLES(OVERRIDE_CYCLES))
    cpu_pm_props_i (
    .sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i), .io_addr_i(io_addr_i), .io_be_i(io_be_i), .io_rd_i(io_rd_i),
    .io_wr_i(io_wr_i), .io_wdata_i(io_wdata_i), .io_rdata_o(io_rdata_o), .power_button_i(power_button_i),
    .sleep_button_i(sleep_button_i), .bm_req_i(bm_req_i), .fw_lock_release_i(fw_lock_release_i),
    .ext_irq_i(ext_irq_i), .sleeping_i(sleeping_i), .enter_working_i(enter_working_i),
    .os_event_interrupt_o(os_event_interrupt_o), .firmware_mgmt_interrupt_o(firmware_mgmt_interrupt_o),
    .wake_o(wake_o), .soft_off_o(soft_off_o), .stop_clock_n_o(stop_clock_n_o), .idle_state_o(idle_state_o));

// >>> sim/cpu_power_state_and_pm_status_tb.sv
// self-checking bench for the processor power state block
`timescale 1ns/100ps
`include "cpu_pm_defs.vh"
`define CHK(nm, exp, got) begin total_checks++; if ((got) !== (exp)) begin n_fail++; \
    $display("ERROR %s expected %h seen %h", nm, exp, got); end end
`define WAITC(cond, lim) begin for (k = 0; k < lim && !(cond); k++) begin @(posedge clk); #1; end \
    if (!(cond)) begin n_fail++; $display("ERROR wait expected 1 seen 0"); tally_and_finish; end end
module cpu_power_state_and_pm_status_tb;
    localparam OVR = 50;
    // pin masks for hold, in the order {pbtn, sbtn, bm, fwrel, entw}
    localparam [4:0] H_PB = 5'h10, H_SB = 5'h08, H_BM = 5'h04, H_FW = 5'h02, H_EW = 5'h01;
    typedef struct packed {logic w; logic [7:0] a; logic [1:0] b; logic [15:0] d;} row_t;
    reg         clk, rst_n, rd, wr, pbtn, sbtn, bm, fwrel, xirq, slp, entw, clr;
    reg  [7:0]  addr;
    reg  [1:0]  be;
    reg  [15:0] wdata;
    wire [15:0] rdata;
    wire        os_irq, fw_irq, wake, soft_off;
    wire [1:0]  stop_n;
    wire [3:0]  idle;
    wire [31:0] run0, run1;
    row_t       rows [0:11];
    int         n_fail, total_checks, k, i, nwake;

    cpu_power_state_and_pm_status #(.NUM_CPU(2), .OVERRIDE_CYCLES(OVR)) cpu_power_state_and_pm_status_i (
        .sys_clk_i(clk), .rst_n_i(rst_n), .io_addr_i(addr), .io_be_i(be), .io_rd_i(rd), .io_wr_i(wr),
        .io_wdata_i(wdata), .io_rdata_o(rdata), .power_button_i(pbtn), .sleep_button_i(sbtn), .bm_req_i(bm),
        .fw_lock_release_i(fwrel), .ext_irq_i(xirq), .sleeping_i(slp), .enter_working_i(entw),
        .os_event_interrupt_o(os_irq), .firmware_mgmt_interrupt_o(fw_irq), .wake_o(wake),
        .soft_off_o(soft_off), .stop_clock_n_o(stop_n), .idle_state_o(idle));
    cpu_model cpu_model_i0 (.sys_clk_i(clk), .rst_n_i(rst_n), .stop_clock_n_i(stop_n[0]), .clear_i(clr),
        .run_cycles_o(run0));
    cpu_model cpu_model_i1 (.sys_clk_i(clk), .rst_n_i(rst_n), .stop_clock_n_i(stop_n[1]), .clear_i(clr),
        .run_cycles_o(run1));

    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end
    always @(posedge clk) begin
        if (wake) nwake <= nwake + 1;
    end
    ////////////////////////////////////////////////////////////////////////////////
    task tally_and_finish;
        $display("checks %0d mismatches %0d", total_checks, n_fail);
        if (n_fail == 0 && total_checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    task acc(input bit w, input [7:0] a, input [1:0] b, input [15:0] d);
        @(posedge clk);
        #1 {wr, rd, addr, be, wdata} = {w, !w, a, b, d};
        @(posedge clk);
        #1 {wr, rd} = 2'b00;
    endtask
    task rdc(input [7:0] a, input [1:0] b, input [15:0] e);
        acc(1'b0, a, b, 16'h0000);
        `CHK("rdata", e, rdata)
    endtask
    task hold(input [4:0] m, input int n);
        {pbtn, sbtn, bm, fwrel, entw} = m;
        repeat (n) @(posedge clk);
        #1 {pbtn, sbtn, bm, fwrel, entw} = 5'h00;
        repeat (8) @(posedge clk);
        #1;
    endtask
    task measure(input int d0, input int d1);
        int p;
        p = 8 * (`THROTTLE_DIV + 1);
        repeat (50) @(posedge clk);
        #1 clr = 1'b1;
        @(posedge clk);
        #1 clr = 1'b0;
        repeat (2 * p) @(posedge clk);
        #1;
        `CHK("run0", 1'b1, run0 >= 2 * p / 8 * d0 && run0 <= 2 * p / 8 * d0 + 4)
        `CHK("run1", 1'b1, run1 >= 2 * p / 8 * d1 && run1 <= 2 * p / 8 * d1 + 4)
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        {n_fail, total_checks, nwake} = 0;
        {rst_n, rd, wr, pbtn, sbtn, bm, fwrel, xirq, slp, entw, clr, addr, be, wdata} = 0;
        rows = '{'{1'b0, 8'h00, 2'h3, 16'h0000}, '{1'b1, 8'h02, 2'h3, 16'hffff},
                 '{1'b0, 8'h02, 2'h3, 16'h0321}, '{1'b1, 8'h02, 2'h1, 16'h0000},
                 '{1'b0, 8'h02, 2'h3, 16'h0300}, '{1'b0, 8'h02, 2'h2, 16'h0300},
                 '{1'b1, 8'h04, 2'h3, 16'hffff}, '{1'b0, 8'h04, 2'h3, 16'h0003},
                 '{1'b0, 8'h40, 2'h3, 16'h0000}, '{1'b1, 8'h18, 2'h3, 16'hffef},
                 '{1'b0, 8'h18, 2'h3, 16'h000e}, '{1'b1, 8'h18, 2'h3, 16'h0000}};
        repeat (2) @(posedge clk);
        `CHK("reset", 6'h30, {stop_n, idle})
        #1 rst_n = 1'b1;
        for (i = 0; i < 12; i++) begin
            if (rows[i].w) acc(1'b1, rows[i].a, rows[i].b, rows[i].d);
            else rdc(rows[i].a, rows[i].b, rows[i].d);
        end
        hold(H_BM, 6);
        rdc(8'h00, 2'h3, 16'h0010);
        acc(1'b1, 8'h00, 2'h3, 16'h0000);
        rdc(8'h00, 2'h3, 16'h0010);
        acc(1'b1, 8'h00, 2'h1, 16'h0010);
        rdc(8'h00, 2'h3, 16'h0000);
        rdc(8'h14, 2'h2, 16'h0000);
        `CHK("idle0", 3'h4, {idle[1:0], stop_n[0]})
        bm = 1'b1;
        `WAITC(idle[1:0] == 2'h0, 10)
        bm = 1'b0;
        rdc(8'h1c, 2'h1, 16'h0000);
        hold(H_BM, 10);
        `CHK("idle1", 3'h2, {idle[3:2], stop_n[1]})
        acc(1'b1, 8'h00, 2'h3, 16'h0010);
        pbtn = 1'b1;
        `WAITC(os_irq, 10)
        `WAITC(idle[3:2] == 2'h0, 4)
        pbtn = 1'b0;
        acc(1'b1, 8'h04, 2'h3, 16'h0002);
        `CHK("route", 2'h1, {os_irq, fw_irq})
        acc(1'b1, 8'h04, 2'h3, 16'h0003);
        acc(1'b1, 8'h00, 2'h2, 16'h0100);
        `CHK("irq", 2'h0, {os_irq, fw_irq})
        rdc(8'h14, 2'h1, 16'h0000);
        `CHK("idle0", 2'h1, idle[1:0])
        xirq = 1'b1;
        `WAITC(idle[1:0] == 2'h0, 10)
        xirq = 1'b0;
        hold(H_FW, 6);
        rdc(8'h00, 2'h3, 16'h0020);
        acc(1'b1, 8'h00, 2'h3, 16'h0020);
        slp = 1'b1;
        acc(1'b1, 8'h02, 2'h3, 16'h0000);
        hold(H_SB, 8);
        `CHK("nwake", 0, nwake)
        rdc(8'h00, 2'h3, 16'h0200);
        acc(1'b1, 8'h00, 2'h3, 16'h0200);
        hold(H_PB, 8);
        `CHK("nwake", 1, nwake)
        rdc(8'h00, 2'h3, 16'h0100);
        acc(1'b1, 8'h00, 2'h3, 16'h0100);
        acc(1'b1, 8'h02, 2'h3, 16'h0200);
        hold(H_SB, 8);
        `CHK("nwake", 2, nwake)
        rdc(8'h00, 2'h3, 16'h0200);
        acc(1'b1, 8'h00, 2'h3, 16'h0200);
        slp = 1'b0;
        pbtn = 1'b1;
        repeat (OVR + 20) @(posedge clk);
        #1;
        `CHK("soft_off", 1'b1, soft_off)
        rdc(8'h00, 2'h3, 16'h0000);
        pbtn = 1'b0;
        hold(H_BM, 6);
        hold(H_EW, 1);
        rdc(8'h00, 2'h3, 16'h0000);
        rdc(8'h02, 2'h3, 16'h0000);
        acc(1'b1, 8'h10, 2'h3, 16'h0002);
        acc(1'b1, 8'h10, 2'h3, 16'h0012);
        acc(1'b1, 8'h18, 2'h3, 16'h000e);
        acc(1'b1, 8'h18, 2'h3, 16'h001e);
        measure(1, 7);
        acc(1'b1, 8'h10, 2'h3, 16'h0002);
        acc(1'b1, 8'h10, 2'h3, 16'h0008);
        acc(1'b1, 8'h10, 2'h3, 16'h0018);
        measure(4, 7);
        tally_and_finish;
    end
endmodule // cpu_power_state_and_pm_status_tb
